// >>> adcrc_top.sv
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`include "adcrc_consts.svh"
module adcrc_top
    import adcrc_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        nrst_i,
    // register port
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    // triggers and dma
    input  wire logic [5:0]  int_trig_i,
    input  wire logic        ext_trig_i,
    input  wire logic        dma_rx_end_i,
    input  wire logic        dma_buf_full_i,
    // analog cell
    output logic             cell_power_o,
    output logic [2:0]       cell_chan_o,
    output logic             cell_sample_o,
    output logic             cell_start_o,
    output logic             cell_reduced_resolution_sel_o,
    input  wire logic [9:0]  cell_data_i,
    // mask output for the interrupt controller
    output logic [19:0]      irq_mask_o
);
    logic         rst_a_q, rst_n;
    logic         wr_ctl, soft_reset, srst_n;
    adcrc_mode_t  mode_q;
    logic [7:0]   chen_q, eoc_q, ovr_q;
    logic         result_ready_flag_q, global_overrun_flag_q, dma_receive_end_flag_q, dma_buffer_full_flag_q;
    logic [19:0]  imask_q;
    logic [9:0]   res_q [8];
    logic [9:0]   last_q;
    logic [2:0]   lastch_q;
    adcrc_state_t st_q;
    logic [8:0]   div_q;
    logic         tick;
    logic [10:0]  cnt_q;
    logic [2:0]   ch_q;
    logic [1:0]   trg_q;
    logic         trg_sel, trg_rise, start_req, sw_start, done_ev;
    logic [9:0]   conv_val;

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_a_q <= 1'b0;
            rst_n   <= 1'b0;
        end else begin
            rst_a_q <= 1'b1;
            rst_n   <= rst_a_q;
        end
    end

    assign wr_ctl   = wr_i && addr_i == `ADCRC_OFF_CTRL;
    // soft reset synchronously clears mode, channel enables, irq mask, sequencer, results and status flags except the dma ones
    assign soft_reset    = wr_ctl && wdata_i[`ADCRC_BIT_SOFT_RESET]; // RULE2
    assign srst_n   = !soft_reset;
    assign sw_start = wr_ctl && wdata_i[`ADCRC_BIT_START]; // RULE1

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= '0;
        end else if (!srst_n) begin
            mode_q <= '0;
        end else if (wr_i && addr_i == `ADCRC_OFF_MODE) begin
            mode_q <= adcrc_mode_t'(wdata_i & `ADCRC_MODE_MASK); // RULE23
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            chen_q <= '0; // RULE12
        end else if (!srst_n) begin
            chen_q <= '0;
        end else if (wr_i && addr_i == `ADCRC_OFF_CHEN) begin
            chen_q <= chen_q | wdata_i[7:0]; // RULE10
        end else if (wr_i && addr_i == `ADCRC_OFF_CHDIS) begin
            chen_q <= chen_q & ~wdata_i[7:0]; // RULE11
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            imask_q <= '0;
        end else if (!srst_n) begin
            imask_q <= '0;
        end else if (wr_i && addr_i == `ADCRC_OFF_IEN) begin
            imask_q <= imask_q | wdata_i[19:0]; // RULE21
        end else if (wr_i && addr_i == `ADCRC_OFF_IDIS) begin
            imask_q <= imask_q & ~wdata_i[19:0]; // RULE21
        end
    end
    assign irq_mask_o = imask_q;

    // trigger edge detect; triggers are taken as synchronous to clk_sys_i
    always_comb begin
        trg_sel = ext_trig_i;
        if (mode_q.trigger_source_sel < `ADCRC_TRG_EXT) begin
            trg_sel = int_trig_i[mode_q.trigger_source_sel]; // RULE8
        end else if (mode_q.trigger_source_sel != `ADCRC_TRG_EXT) begin
            trg_sel = 1'b0;
        end
    end
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            trg_q <= '0;
        end else begin
            trg_q <= {trg_q[0], trg_sel};
        end
    end
    assign trg_rise  = trg_q[0] && !trg_q[1] && mode_q.hw_trigger_en; // RULE9 RULE22
    assign start_req = sw_start || trg_rise;

    // divided converter clock as a one-cycle tick
    // nine bits: the largest prescaler needs a reload of 511
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= '0;
        end else if (st_q == ADCRC_IDLE || div_q == '0) begin
            div_q <= 9'((({2'b00, mode_q.clock_divider_sel} + 10'h1) << 1) - 10'h1); // RULE5
        end else begin
            div_q <= div_q - 9'h1;
        end
    end
    assign tick = st_q != ADCRC_IDLE && div_q == '0;

    assign conv_val = mode_q.reduced_resolution_sel ? {2'b00, cell_data_i[9:2]} : cell_data_i; // RULE7
    assign done_ev  = st_q == ADCRC_CONV && tick && cnt_q == 11'h1;

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            st_q  <= ADCRC_IDLE;
            cnt_q <= '0;
            ch_q  <= '0;
        end else if (!srst_n) begin
            st_q  <= ADCRC_IDLE;
            cnt_q <= '0;
            ch_q  <= '0;
        end else begin
            case (st_q)
                ADCRC_IDLE: begin
                    if (start_req && chen_q != '0) begin
                        ch_q <= '0;
                        if (mode_q.sleep) begin
                            st_q  <= ADCRC_WAKE; // RULE18 RULE6
                            cnt_q <= 11'({4'h0, mode_q.startup} + 11'h1) << `ADCRC_SU_MULT; // RULE4
                        end else begin
                            st_q <= ADCRC_PICK;
                        end
                    end
                end
                ADCRC_WAKE: begin
                    if (tick) begin
                        cnt_q <= cnt_q - 11'h1;
                        if (cnt_q == 11'h1) begin
                            st_q <= ADCRC_PICK;
                        end
                    end
                end
                ADCRC_PICK: begin
                    if (chen_q[ch_q]) begin
                        st_q  <= ADCRC_SHOLD;
                        cnt_q <= 11'({7'h0, mode_q.sample_hold_cycles} + 11'(`ADCRC_SH_EXTRA)); // RULE3
                    end else if (ch_q == 3'h7) begin
                        st_q <= ADCRC_IDLE;
                    end else begin
                        ch_q <= ch_q + 3'h1;
                    end
                end
                ADCRC_SHOLD: begin
                    if (tick) begin
                        cnt_q <= cnt_q - 11'h1;
                        if (cnt_q == 11'h1) begin
                            st_q  <= ADCRC_CONV;
                            cnt_q <= 11'(`ADCRC_CONV_CYC);
                        end
                    end
                end
                ADCRC_CONV: begin
                    if (tick) begin
                        cnt_q <= cnt_q - 11'h1;
                        if (cnt_q == 11'h1) begin
                            if (ch_q == 3'h7) begin
                                st_q <= ADCRC_IDLE;
                            end else begin
                                ch_q <= ch_q + 3'h1;
                                st_q <= ADCRC_PICK;
                            end
                        end
                    end
                end
                default: st_q <= ADCRC_IDLE;
            endcase
        end
    end

    // cell stays powered in normal mode; sleep mode powers it only while busy
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            cell_power_o  <= 1'b0;
            cell_chan_o   <= '0;
            cell_sample_o <= 1'b0;
            cell_start_o  <= 1'b0;
            cell_reduced_resolution_sel_o <= 1'b0;
        end else begin
            cell_power_o  <= !mode_q.sleep || st_q != ADCRC_IDLE; // RULE6 RULE18
            cell_chan_o   <= ch_q;
            cell_sample_o <= st_q == ADCRC_SHOLD;
            cell_start_o  <= st_q == ADCRC_SHOLD && tick && cnt_q == 11'h1;
            cell_reduced_resolution_sel_o <= mode_q.reduced_resolution_sel;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 8; i++) begin
                res_q[i] <= '0; // RULE16
            end
            last_q   <= '0;
            lastch_q <= '0;
        end else if (!srst_n) begin
            for (int i = 0; i < 8; i++) begin
                res_q[i] <= '0;
            end
            last_q   <= '0;
            lastch_q <= '0;
        end else if (done_ev) begin
            res_q[ch_q] <= conv_val;
            last_q      <= conv_val;
            lastch_q    <= ch_q;
        end
    end

    // status flags: a new conversion wins over a clearing read in the same cycle
    logic       rd_stat, rd_last, rd_res;
    logic [7:0] ch_hot, rd_hot;
    assign rd_stat = rd_i && addr_i == `ADCRC_OFF_STAT;
    assign rd_last = rd_i && addr_i == `ADCRC_OFF_LAST;
    assign rd_res  = rd_i && addr_i >= `ADCRC_OFF_RES0 && addr_i <= `ADCRC_OFF_RES7
                     && addr_i[1:0] == 2'b00;
    assign ch_hot  = done_ev ? (8'h1 << ch_q) : 8'h0;
    always_comb begin
        rd_hot = '0;
        if (rd_res) begin
            rd_hot = 8'h1 << 3'(addr_i[5:2] - 4'hc); // RULE19
        end
        if (rd_last) begin
            rd_hot = rd_hot | (8'h1 << lastch_q); // RULE19
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            eoc_q   <= '0;
            ovr_q   <= '0;
            result_ready_flag_q  <= 1'b0;
            global_overrun_flag_q <= 1'b0;
        end else if (!srst_n) begin
            eoc_q   <= '0;
            ovr_q   <= '0;
            result_ready_flag_q  <= 1'b0;
            global_overrun_flag_q <= 1'b0;
        end else begin
            eoc_q   <= (eoc_q & ~rd_hot) | ch_hot;
            ovr_q   <= (rd_stat ? 8'h0 : ovr_q) | (ch_hot & eoc_q); // RULE20
            result_ready_flag_q  <= (result_ready_flag_q && !rd_last) || done_ev;
            global_overrun_flag_q <= (global_overrun_flag_q && !rd_stat) || (done_ev && result_ready_flag_q); // RULE20
        end
    end

    // dma flags follow their inputs; reset value sets both high
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            dma_receive_end_flag_q  <= 1'b1;
            dma_buffer_full_flag_q <= 1'b1;
        end else begin
            dma_receive_end_flag_q  <= dma_rx_end_i;
            dma_buffer_full_flag_q <= dma_buf_full_i; // RULE15
        end
    end

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = '0; // RULE23
        case (addr_i)
            `ADCRC_OFF_MODE:   rd_mux = 32'(mode_q);
            `ADCRC_OFF_CHSTAT: rd_mux = {24'h0, chen_q}; // RULE12
            `ADCRC_OFF_STAT:   rd_mux = {12'h0, dma_buffer_full_flag_q, dma_receive_end_flag_q, global_overrun_flag_q, result_ready_flag_q,
                                         ovr_q, eoc_q}; // RULE14
            `ADCRC_OFF_LAST:   rd_mux = {22'h0, last_q};
            `ADCRC_OFF_IMASK:  rd_mux = {12'h0, imask_q};
            `ADCRC_OFF_REV:    rd_mux = `ADCRC_REV_VALUE; // arbitrary value RULE17
            default: begin
                if (rd_res) begin
                    rd_mux = {22'h0, res_q[3'(addr_i[5:2] - 4'hc)]};
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= rd_i ? rd_mux : 32'h0;
        end
    end

    chk_start_launch: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE1
        (st_q == ADCRC_IDLE && sw_start && !soft_reset && chen_q != '0) |=> st_q != ADCRC_IDLE)
        else $error("start did not launch a sequence");
    chk_soft_reset_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE2
        soft_reset |=> (chen_q == '0 && mode_q == '0 && st_q == ADCRC_IDLE))
        else $error("soft reset left state behind");
    chk_chen_set: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE10
        (wr_i && addr_i == `ADCRC_OFF_CHEN) |=> ((chen_q & $past(wdata_i[7:0])) == $past(wdata_i[7:0])))
        else $error("channel enable failed");
    chk_chdis_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE11
        (wr_i && addr_i == `ADCRC_OFF_CHDIS) |=> ((chen_q & $past(wdata_i[7:0])) == 8'h0))
        else $error("channel disable failed");
    chk_dma_buffer_full_flag_follow: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE15
        ##1 dma_buffer_full_flag_q == $past(dma_buf_full_i))
        else $error("buffer full flag does not follow");
    chk_ovr_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE20
        (rd_stat && !done_ev) |=> (ovr_q == '0 && !global_overrun_flag_q))
        else $error("overrun flags not cleared by status read");
    chk_trig_ignore: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE9
        (st_q == ADCRC_IDLE && !mode_q.hw_trigger_en && !sw_start) |=> st_q == ADCRC_IDLE)
        else $error("sequence started without enabled trigger");
    chk_result_ready_flag_set: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE19
        (done_ev && !soft_reset) |=> (result_ready_flag_q && eoc_q[$past(ch_q)]))
        else $error("ready not set on conversion end");
    // register map, flag and sequencer checks
    chk_reduced_resolution_sel_data: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE7
        (done_ev && !soft_reset && mode_q.reduced_resolution_sel) |=> last_q[9:8] == 2'b00)
        else $error("reduced result too wide");
    chk_sleep_power: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE18
        (mode_q.sleep && st_q == ADCRC_IDLE) |=> !cell_power_o)
        else $error("idle cell powered in sleep");
    // sampled rst_n keeps the first edge after reset out
    chk_normal_power: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE6
        (rst_n && !mode_q.sleep) |=> cell_power_o)
        else $error("cell off in normal mode");
    chk_tick_gap: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE5
        tick |=> !tick)
        else $error("divided clock too fast");
    chk_rsvd_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE23
        (rd_i && addr_i == `ADCRC_OFF_STAT) |=> rdata_o[31:20] == 12'h0)
        else $error("reserved status bits set");
    chk_wo_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE1 RULE10
        (rd_i && (addr_i == `ADCRC_OFF_CTRL || addr_i == `ADCRC_OFF_CHEN)) |=> rdata_o == 32'h0)
        else $error("write-only read nonzero");
    chk_res0_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE19
        (rd_i && addr_i == `ADCRC_OFF_RES0 && !done_ev) |=> !eoc_q[0])
        else $error("result read kept done flag");
    chk_last_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE19
        (rd_last && !done_ev) |=> !result_ready_flag_q)
        else $error("last read kept ready");
    chk_rev_read: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE17
        (rd_i && addr_i == `ADCRC_OFF_REV) |=> rdata_o == `ADCRC_REV_VALUE)
        else $error("revision misread");
    chk_trig_start: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE22
        (st_q == ADCRC_IDLE && trg_rise && !soft_reset && chen_q != '0) |=> st_q != ADCRC_IDLE)
        else $error("trigger edge ignored");
    chk_ovr_set: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // RULE14
        (done_ev && !soft_reset && eoc_q[ch_q]) |=> ovr_q[$past(ch_q)])
        else $error("overrun not flagged");
endmodule

// >>> adcrc_consts.svh
// What this block does
// RULE1: writing one to start launches a sequence; zero ignored; reads zero
// RULE2: writing one to soft reset returns controller to reset; reads zero
// RULE3: sample-hold lasts field plus 3 divided clock periods
// RULE4: start-up wait lasts (field plus 1) times 8 divided clock periods
// RULE5: divided clock is input clock over twice (prescaler plus one)
// RULE6: sleep bit one selects sleep operation, zero normal
// RULE7: resolution bit one gives 8-bit results, zero 10-bit; resets zero
// RULE8: trigger select codes 0..5 internal triggers, code 6 external trigger
// RULE9: trigger enable zero ignores hardware triggers; software start still works
// RULE10: ones written to channel enable set channel status bits
// RULE11: ones written to channel disable clear channel status bits
// RULE12: channel status shows enabled channels; all disabled after reset
// RULE13: software must not disable channels while a conversion runs
// RULE14: status layout done, overrun, ready, global overrun, dma flags; resets 0xc0000
// RULE15: dma buffer-full status bit follows the dma buffer-full signal
// RULE16: eight read-only channel results at 0x30..0x4c, reset zero
// RULE17: read-only revision register at 0xfc, fixed content
// RULE18: sleep start powers cell, waits start-up, converts, powers down; busy ignores triggers
// RULE19: channel result read clears its done flag; last result read clears ready too
// RULE20: status read clears channel and global overrun flags
// RULE21: irq enable ones set mask bits, irq disable ones clear them
// RULE22: enabled hardware trigger starts on each synchronised rising edge
// RULE23: reserved bits ignore writes and read zero
`ifndef ADCRC_CONSTS_SVH
`define ADCRC_CONSTS_SVH
`define ADCRC_OFF_CTRL      8'h00
`define ADCRC_OFF_MODE      8'h04
`define ADCRC_OFF_CHEN      8'h10
`define ADCRC_OFF_CHDIS     8'h14
`define ADCRC_OFF_CHSTAT    8'h18
`define ADCRC_OFF_STAT      8'h1c
`define ADCRC_OFF_LAST      8'h20
`define ADCRC_OFF_IEN       8'h24
`define ADCRC_OFF_IDIS      8'h28
`define ADCRC_OFF_IMASK     8'h2c
`define ADCRC_OFF_RES0      8'h30
`define ADCRC_OFF_RES7      8'h4c
`define ADCRC_OFF_REV       8'hfc
`define ADCRC_BIT_SOFT_RESET     0
`define ADCRC_BIT_START     1
`define ADCRC_MODE_MASK     32'h0f7f_ff3f
`define ADCRC_STAT_MASK     32'h000f_ffff
`define ADCRC_STAT_RESET    32'h000c_0000
`define ADCRC_REV_VALUE     32'h0000_0100
`define ADCRC_SH_EXTRA      8'h03
`define ADCRC_SU_MULT       3
`define ADCRC_TRG_EXT       3'h6
`define ADCRC_CONV_CYC      8'h0a
`endif

// >>> adcrc_pkg.sv
package adcrc_pkg;
    typedef struct packed {
        logic [3:0] sample_hold_cycles;
        logic       rsv0;
        logic [6:0] startup;
        logic [7:0] clock_divider_sel;
        logic [1:0] rsv1;
        logic       sleep;
        logic       reduced_resolution_sel;
        logic [2:0] trigger_source_sel;
        logic       hw_trigger_en;
    } adcrc_mode_t;
    typedef enum logic [2:0] {
        ADCRC_IDLE  = 3'b000,
        ADCRC_WAKE  = 3'b001,
        ADCRC_PICK  = 3'b010,
        ADCRC_SHOLD = 3'b011,
        ADCRC_CONV  = 3'b100
    } adcrc_state_t;
endpackage

// >>> adcrc_cell_model.sv
`timescale 1ns/1ps
module adcrc_cell_model (
    // clock
    input  wire logic       clk_sys_i,
    // controls from the block, and base_i from the testbench
    input  wire logic       cell_power_i,
    input  wire logic [2:0] cell_chan_i,
    input  wire logic       cell_start_i,
    input  wire logic [6:0] base_i,
    // conversion result
    output logic      [9:0] cell_data_o
);
    initial cell_data_o = 10'h155;
    // the channel number is carried in the result, so a swapped channel shows up
    always @(posedge clk_sys_i) begin
        if (cell_start_i === 1'b1) begin
            cell_data_o <= {cell_chan_i, base_i};
        end else if (cell_power_i !== 1'b1) begin
            // an unpowered cell gives garbage, inverting its output every cycle
            cell_data_o <= ~cell_data_o;
        end
    end
endmodule

// >>> adcrc_top_tb.sv
`timescale 1ns/1ps
`include "adcrc_consts.svh"
module adcrc_top_tb;
    logic        clk_sys_i, nrst_i, wr_i, rd_i, ext_trig_i, dma_rx_end_i, dma_buf_full_i;
    logic [7:0]  addr_i;
    logic [31:0] wdata_i, rdata_o, rdv, d;
    logic [5:0]  int_trig_i;
    logic        cell_power_o, cell_sample_o, cell_start_o, cell_reduced_resolution_sel_o;
    logic [2:0]  cell_chan_o;
    logic [9:0]  cell_data_i;
    logic [19:0] irq_mask_o;
    logic [6:0]  base;
    logic        pow_d = 0, samp_d = 0, armed = 0;
    integer      seed = 36548, num_errors = 0, n_compared = 0;
    integer      cyc = 0, n_starts = 0, sh_run = 0, sh_len = 0, su_len = 0, t_pow = 0;
    integer      chm, imk, mask, nch, div, p, s, su, lr, md, a, i, n0, c;

    adcrc_top u_dut (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .int_trig_i(int_trig_i),
        .ext_trig_i(ext_trig_i), .dma_rx_end_i(dma_rx_end_i),
        .dma_buf_full_i(dma_buf_full_i), .cell_power_o(cell_power_o),
        .cell_chan_o(cell_chan_o), .cell_sample_o(cell_sample_o),
        .cell_start_o(cell_start_o), .cell_reduced_resolution_sel_o(cell_reduced_resolution_sel_o),
        .cell_data_i(cell_data_i), .irq_mask_o(irq_mask_o));
    adcrc_cell_model u_cell (
        .clk_sys_i(clk_sys_i), .cell_power_i(cell_power_o), .cell_chan_i(cell_chan_o),
        .cell_start_i(cell_start_o), .base_i(base), .cell_data_o(cell_data_i));

    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    // timing monitor: start pulses, sample-hold length, power-up to first sample
    always @(posedge clk_sys_i) begin
        cyc = cyc + 1;
        if (cell_start_o === 1'b1) n_starts = n_starts + 1;
        if (cell_sample_o === 1'b1) sh_run = sh_run + 1;
        else if (sh_run != 0) begin
            sh_len = sh_run;
            sh_run = 0;
        end
        if (cell_power_o === 1'b1 && !pow_d) begin
            t_pow = cyc;
            armed = 1'b1;
        end
        if (cell_sample_o === 1'b1 && !samp_d && armed) begin
            su_len = cyc - t_pow;
            armed = 1'b0;
        end
        pow_d = (cell_power_o === 1'b1);
        samp_d = (cell_sample_o === 1'b1);
    end

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] dat);
        @(posedge clk_sys_i);
        addr_i <= ad;
        wdata_i <= dat;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] ad, input logic [31:0] exp);
        @(posedge clk_sys_i);
        addr_i <= ad;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1 rdv = rdata_o;
        chk(rdv, exp);
    endtask

    // timing figures may slip by one divided-clock period plus a state or two
    function automatic integer near(input integer m, input integer e);
        return ((m - e <= div + 2) && (e - m <= div + 2)) ? 1 : 0;
    endfunction

    function automatic integer expd(input integer ch);
        integer v;
        v = ch * 128 + base;
        return (lr != 0) ? v / 4 : v;
    endfunction

    task automatic cfg(input integer slp, input integer tsel, input integer ten);
        p = $unsigned($random(seed)) % 3;
        s = $unsigned($random(seed)) % 4;
        su = $unsigned($random(seed)) % 4;
        lr = $unsigned($random(seed)) % 2;
        div = 2 * (p + 1);
        md = (s << 24) | (su << 16) | (p << 8) | (slp << 5) | (lr << 4) | (tsel << 1) | ten;
        wr(`ADCRC_OFF_MODE, md);
        rchk(`ADCRC_OFF_MODE, md);
    endtask

    task automatic trig(input integer code);
        @(posedge clk_sys_i);
        if (code < 6) int_trig_i <= 6'h01 << code;
        else ext_trig_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        int_trig_i <= 6'h00;
        ext_trig_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
    endtask

    // software leaves the channel set alone until the whole sequence is over
    task automatic seq_wait(input integer n);
        integer k;
        for (k = 0; k < 5000 && n_starts < n0 + n; k++) @(posedge clk_sys_i) #1;
        if (n_starts < n0 + n) begin
            num_errors = num_errors + 1;
            tally_and_finish();
        end
        repeat (12 * div + 8) @(posedge clk_sys_i);
        #1;
        chk(n_starts - n0, n);
    endtask

    initial begin
        repeat (90000) @(posedge clk_sys_i);
        num_errors = num_errors + 1;
        tally_and_finish();
    end

    initial begin
        nrst_i = 1'b0; addr_i = 8'h00; wdata_i = 32'h0; wr_i = 1'b0; rd_i = 1'b0;
        int_trig_i = 6'h00; ext_trig_i = 1'b0; dma_rx_end_i = 1'b1; dma_buf_full_i = 1'b1;
        base = 7'h2a;
        div = 2;
        repeat (12) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        for (a = 0; a < 256; a += 4) begin
            if ((a >= 8'h18 && a <= 8'h20) || a == 8'h2c || (a >= 8'h30 && a <= 8'h4c) ||
                a == 8'hfc) wr(8'(a), $random(seed));
            rchk(8'(a), a == 8'h1c ? `ADCRC_STAT_RESET : a == 8'hfc ? `ADCRC_REV_VALUE : 0);
        end
        repeat (4) begin
            md = $random(seed);
            wr(`ADCRC_OFF_MODE, md);
            rchk(`ADCRC_OFF_MODE, md & `ADCRC_MODE_MASK);
        end
        chm = 0;
        imk = 0;
        repeat (6) begin
            d = $random(seed); wr(`ADCRC_OFF_CHEN, d); chm = chm | (d & 255);
            rchk(`ADCRC_OFF_CHSTAT, chm);
            d = $random(seed); wr(`ADCRC_OFF_CHDIS, d); chm = chm & ~d & 255;
            rchk(`ADCRC_OFF_CHSTAT, chm);
            d = $random(seed); wr(`ADCRC_OFF_IEN, d); imk = imk | (d & 32'hfffff);
            d = $random(seed); wr(`ADCRC_OFF_IDIS, d); imk = imk & ~d & 32'hfffff;
            rchk(`ADCRC_OFF_IMASK, imk);
            chk({12'h000, irq_mask_o}, imk);
        end
        repeat (4) begin
            d = $random(seed);
            @(posedge clk_sys_i);
            dma_rx_end_i <= d[0];
            dma_buf_full_i <= d[1];
            repeat (2) @(posedge clk_sys_i);
            rchk(`ADCRC_OFF_STAT, {12'h000, d[1:0], 18'h0});
        end
        dma_rx_end_i <= 1'b0;
        dma_buf_full_i <= 1'b0;
        wr(`ADCRC_OFF_CHEN, 32'hff);
        wr(`ADCRC_OFF_IEN, 32'hfffff);
        wr(`ADCRC_OFF_MODE, 32'h0100_0101);
        n0 = n_starts;
        wr(`ADCRC_OFF_CTRL, 32'h0);
        repeat (100) @(posedge clk_sys_i);
        chk(n_starts - n0, 0);
        wr(`ADCRC_OFF_CTRL, 32'h1);
        rchk(`ADCRC_OFF_MODE, 0);
        rchk(`ADCRC_OFF_CHSTAT, 0);
        rchk(`ADCRC_OFF_IMASK, 0);
        cfg(0, 0, 0);
        mask = ($random(seed) & 255) | 8'h81;
        nch = 0;
        for (i = 0; i < 8; i++) nch = nch + mask[i];
        base = $random(seed);
        wr(`ADCRC_OFF_CHEN, mask);
        n0 = n_starts;
        wr(`ADCRC_OFF_CTRL, 32'h2);
        seq_wait(nch);
        chk(near(sh_len, (s + 3) * div), 1);
        chk(cell_reduced_resolution_sel_o, lr);
        rchk(`ADCRC_OFF_STAT, mask | 32'h3_0000);
        for (i = 0; i < 8; i++) if (mask[i]) rchk(8'(`ADCRC_OFF_RES0 + 4 * i), expd(i));
        rchk(`ADCRC_OFF_LAST, expd(7));
        rchk(`ADCRC_OFF_STAT, 0);
        n0 = n_starts;
        wr(`ADCRC_OFF_CTRL, 32'h2);
        seq_wait(nch);
        // results left unread, so the next pass overruns every enabled channel
        n0 = n_starts;
        wr(`ADCRC_OFF_CTRL, 32'h2);
        seq_wait(nch);
        rchk(`ADCRC_OFF_STAT, mask | (mask << 8) | 32'h3_0000);
        rchk(`ADCRC_OFF_STAT, mask | 32'h1_0000);
        wr(`ADCRC_OFF_CHDIS, 32'hff);
        wr(`ADCRC_OFF_CHEN, 32'h01);
        for (c = 0; c < 7; c++) begin
            cfg(0, c, 1);
            n0 = n_starts;
            trig((c + 1) % 7);
            repeat (100) @(posedge clk_sys_i);
            chk(n_starts - n0, 0);
            trig(c);
            seq_wait(1);
        end
        cfg(0, 6, 0);
        n0 = n_starts;
        trig(6);
        cfg(0, 7, 1);
        trig(6);
        trig(0);
        repeat (100) @(posedge clk_sys_i);
        chk(n_starts - n0, 0);
        cfg(1, 6, 1);
        repeat (5) @(posedge clk_sys_i);
        chk(cell_power_o, 0);
        n0 = n_starts;
        wr(`ADCRC_OFF_CTRL, 32'h2);
        repeat (6) @(posedge clk_sys_i);
        trig(6);
        seq_wait(1);
        chk(near(su_len, (su + 1) * 8 * div), 1);
        chk(cell_power_o, 0);
        tally_and_finish();
    end
endmodule
